// ==== rtl/fpc_pkg.sv ====
package fpc_pkg;
  localparam int AW = 15;
  localparam int DW = 16;
  localparam int CLK_MHZ = 200;

  typedef enum logic [2:0] {
    FPC_OP_READ = 3'h0,
    FPC_OP_PROG = 3'h1,
    FPC_OP_CHIP_ERASE = 3'h2,
    FPC_OP_MAIN_ERASE = 3'h3,
    FPC_OP_ID_READ = 3'h4,
    FPC_OP_ID_EXIT = 3'h5,
    FPC_OP_LOCKOUT = 3'h6
  } fpc_op_t;

  // command codes: only the low byte is decoded by the part
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_SETUP = 8'ha0;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [7:0] CMD_LOCKOUT = 8'h40;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_MAIN_ERASE = 8'h30;
  localparam logic [AW-1:0] UNLOCK_ADDR1 = 15'h5555;
  localparam logic [AW-1:0] UNLOCK_ADDR2 = 15'h2aaa;

  localparam int TOGGLE_BIT_POS = 6;
  localparam logic [AW-1:0] BOOT_LO_ADDR = 15'h0000;
  localparam logic [AW-1:0] BOOT_HI_ADDR = 15'h1fff;

  // pin timing in ns, converted to clock counts (minimums round up)
  localparam int TWP_NS = 90;
  localparam int TWPH_NS = 90;
  localparam int TACC_NS = 90;
  localparam int TOEHP_NS = 150;
  localparam logic [7:0] TWP_CYC = 8'((TWP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TWPH_CYC = 8'((TWPH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TACC_CYC = 8'((TACC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TOEHP_CYC = 8'((TOEHP_NS * CLK_MHZ + 999) / 1000);

  // longest operation times, used as polling timeouts
  localparam int TBP_MAX_US = 50;
  localparam int TEC_MAX_S = 10;
  localparam int PROG_MAX_CYC = TBP_MAX_US * CLK_MHZ;
  localparam int ERASE_MAX_CYC = TEC_MAX_S * CLK_MHZ * 1000000;
endpackage : fpc_pkg

// ==== rtl/fpc_cycle.sv ====
`timescale 1ns/1ps
// one flash bus cycle: a timed write pulse or a timed read with oe high recovery
module fpc_cycle (
  input wire logic ref_clk_in, // 200 MHz clock
  input wire logic rst_b_in, // sync reset, active low
  input wire logic start_in, // pulse: begin a cycle
  input wire logic write_in, // 1 write, 0 read
  input wire logic [fpc_pkg::AW-1:0] addr_in, // cycle address
  input wire logic [fpc_pkg::DW-1:0] wdata_in, // write data
  input wire logic [fpc_pkg::DW-1:0] flash_dq_in, // data pins in
  output logic flash_ce_b_out, // chip enable, low active
  output logic flash_oe_b_out, // output enable, low active
  output logic flash_we_b_out, // write strobe, low active
  output logic [fpc_pkg::AW-1:0] flash_addr_out, // address pins
  output logic [fpc_pkg::DW-1:0] flash_dq_out, // data pins out
  output logic flash_dq_oe_out, // high while driving data
  output logic [fpc_pkg::DW-1:0] rdata_out, // sampled read data
  output logic done_out // pulse: cycle finished
);
  import fpc_pkg::*;

  typedef enum logic [2:0] {
    CY_IDLE = 3'b001,
    CY_ACT = 3'b010,
    CY_REC = 3'b100
  } fpc_cy_t;

  fpc_cy_t st_q;
  logic wr_q;
  logic [7:0] cnt_q;
  wire cnt_zero = (cnt_q == 8'h00);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_q <= CY_IDLE;
      wr_q <= 1'b0;
      cnt_q <= 8'h00;
      flash_ce_b_out <= 1'b1;
      flash_oe_b_out <= 1'b1;
      flash_we_b_out <= 1'b1;
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_out <= 1'b0;
      rdata_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (st_q)
        CY_IDLE: begin
          if (start_in) begin
            st_q <= CY_ACT;
            wr_q <= write_in;
            flash_addr_out <= addr_in;
            flash_dq_out <= wdata_in;
            flash_ce_b_out <= 1'b0;
            // oe stays high for the whole low phase of a write
            flash_oe_b_out <= write_in;
            flash_we_b_out <= !write_in;
            flash_dq_oe_out <= write_in;
            cnt_q <= write_in ? TWP_CYC - 8'h01 : TACC_CYC - 8'h01;
          end
        end
        CY_ACT: begin
          if (cnt_zero) begin
            st_q <= CY_REC;
            flash_ce_b_out <= 1'b1;
            flash_we_b_out <= 1'b1;
            flash_oe_b_out <= 1'b1;
            if (!wr_q) begin
              rdata_out <= flash_dq_in;
            end
            cnt_q <= wr_q ? TWPH_CYC - 8'h01 : TOEHP_CYC - 8'h01;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        CY_REC: begin
          if (cnt_zero) begin
            st_q <= CY_IDLE;
            flash_dq_oe_out <= 1'b0;
            done_out <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          st_q <= CY_IDLE;
        end
      endcase
    end
  end
endmodule : fpc_cycle

// ==== rtl/fpc_host.sv ====
`timescale 1ns/1ps
module fpc_host #(
  parameter int PROG_LIMIT_CYC = fpc_pkg::PROG_MAX_CYC, // program poll timeout
  parameter int ERASE_LIMIT_CYC = fpc_pkg::ERASE_MAX_CYC // erase poll timeout
) (
  input wire logic ref_clk_in, // 200 MHz clock
  input wire logic rst_b_in, // sync reset, active low
  input wire logic cmd_valid_in, // request strobe
  input wire fpc_pkg::fpc_op_t cmd_op_in, // requested operation
  input wire logic [fpc_pkg::AW-1:0] cmd_addr_in, // word address
  input wire logic [fpc_pkg::DW-1:0] cmd_wdata_in, // program data
  output logic cmd_ready_out, // idle and able to take a request
  output logic done_out, // pulse: operation finished
  output logic [fpc_pkg::DW-1:0] rdata_out, // read or id data
  output logic timeout_out, // operation did not finish in time
  output logic boot_hit_out, // last accepted command was a program into the boot block
  input wire logic [fpc_pkg::DW-1:0] flash_dq_in, // data pins in
  output logic flash_ce_b_out, // chip enable, low active
  output logic flash_oe_b_out, // output enable, low active
  output logic flash_we_b_out, // write strobe, low active
  output logic [fpc_pkg::AW-1:0] flash_addr_out, // address pins
  output logic [fpc_pkg::DW-1:0] flash_dq_out, // data pins out
  output logic flash_dq_oe_out // high while driving data
);
  import fpc_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WR = 5'b00010,
    ST_POLL = 5'b00100,
    ST_RD = 5'b01000,
    ST_END = 5'b10000
  } fpc_state_t;

  fpc_state_t state_q;
  fpc_op_t op_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [2:0] idx_q;
  logic pend_q;
  logic start_q;
  logic prev_tog_q;
  logic have_prev_q;
  logic [31:0] wait_q;
  logic [31:0] limit_q;
  logic [DW-1:0] cyc_rdata;
  logic cyc_done;

  // one command step: {last, address, data}; upper data byte is zero except in the program data word
  function automatic logic [AW+DW:0] step_f(input fpc_op_t op, input logic [2:0] idx,
                                           input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [7:0] code;
    logic [AW-1:0] ca;
    logic last;
    code = 8'h00;
    ca = UNLOCK_ADDR1;
    last = 1'b0;
    case (idx)
      3'h0: code = CMD_UNLOCK1;
      3'h1: begin
        code = CMD_UNLOCK2;
        ca = UNLOCK_ADDR2;
      end
      3'h2: begin
        case (op)
          FPC_OP_PROG: code = CMD_PROG_SETUP;
          FPC_OP_ID_READ: code = CMD_ID_ENTRY;
          FPC_OP_ID_EXIT: code = CMD_ID_EXIT;
          default: code = CMD_ERASE_SETUP;
        endcase
        last = (op == FPC_OP_ID_READ) || (op == FPC_OP_ID_EXIT);
      end
      3'h3: code = CMD_UNLOCK1;
      3'h4: begin
        code = CMD_UNLOCK2;
        ca = UNLOCK_ADDR2;
      end
      default: begin
        case (op)
          FPC_OP_CHIP_ERASE: code = CMD_CHIP_ERASE;
          FPC_OP_MAIN_ERASE: code = CMD_MAIN_ERASE;
          default: code = CMD_LOCKOUT;
        endcase
        last = 1'b1;
      end
    endcase
    if ((op == FPC_OP_PROG) && (idx == 3'h3)) begin
      return {1'b1, a, d};
    end
    return {last, ca, 8'h00, code};
  endfunction : step_f

  wire [AW+DW:0] step_w = step_f(op_q, idx_q, addr_q, wdata_q);
  wire step_last = step_w[AW+DW];
  wire [AW-1:0] step_addr = step_w[AW+DW-1:DW];
  wire [DW-1:0] step_data = step_w[DW-1:0];
  wire needs_poll = (op_q == FPC_OP_PROG) || (op_q == FPC_OP_CHIP_ERASE) ||
                    (op_q == FPC_OP_MAIN_ERASE) || (op_q == FPC_OP_LOCKOUT);
  // id codes sit at address zero and one
  wire [AW-1:0] id_addr = {{(AW-1){1'b0}}, addr_q[0]};
  wire [AW-1:0] rd_addr = (op_q == FPC_OP_ID_READ) ? id_addr : addr_q;
  wire [AW-1:0] cyc_addr = (state_q == ST_WR) ? step_addr : rd_addr;
  wire cyc_write = (state_q == ST_WR);
  wire cur_tog = cyc_rdata[TOGGLE_BIT_POS];
  wire tog_settled = have_prev_q && (cur_tog == prev_tog_q);
  wire timed_out = (wait_q >= limit_q);
  wire issue = !pend_q && !start_q && (state_q != ST_IDLE) && (state_q != ST_END);
  wire in_boot = (cmd_addr_in >= BOOT_LO_ADDR) && (cmd_addr_in <= BOOT_HI_ADDR);
  wire [31:0] op_limit = (cmd_op_in == FPC_OP_PROG) ? 32'(PROG_LIMIT_CYC) : 32'(ERASE_LIMIT_CYC);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      start_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      start_q <= issue;
      if (issue) begin
        pend_q <= 1'b1;
      end else if (cyc_done) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wait_q <= 32'h0000_0000;
    end else if (state_q == ST_POLL) begin
      wait_q <= wait_q + 32'h0000_0001;
    end else begin
      wait_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      op_q <= FPC_OP_READ;
      addr_q <= '0;
      wdata_q <= '0;
      idx_q <= 3'h0;
      limit_q <= 32'h0000_0000;
      prev_tog_q <= 1'b0;
      have_prev_q <= 1'b0;
      cmd_ready_out <= 1'b1;
      done_out <= 1'b0;
      rdata_out <= '0;
      timeout_out <= 1'b0;
      boot_hit_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid_in) begin
            op_q <= cmd_op_in;
            addr_q <= cmd_addr_in;
            wdata_q <= cmd_wdata_in;
            idx_q <= 3'h0;
            limit_q <= op_limit;
            have_prev_q <= 1'b0;
            timeout_out <= 1'b0;
            cmd_ready_out <= 1'b0;
            boot_hit_out <= (cmd_op_in == FPC_OP_PROG) && in_boot;
            state_q <= (cmd_op_in == FPC_OP_READ) ? ST_RD : ST_WR;
          end
        end
        ST_WR: begin
          if (cyc_done) begin
            if (!step_last) begin
              idx_q <= idx_q + 3'h1;
            end else if (needs_poll) begin
              state_q <= ST_POLL;
            end else if (op_q == FPC_OP_ID_READ) begin
              state_q <= ST_RD;
            end else begin
              state_q <= ST_END;
            end
          end
        end
        ST_POLL: begin
          if (cyc_done) begin
            prev_tog_q <= cur_tog;
            have_prev_q <= 1'b1;
            rdata_out <= cyc_rdata;
            if (tog_settled) begin
              state_q <= ST_END;
            end else if (timed_out) begin
              timeout_out <= 1'b1;
              state_q <= ST_END;
            end
          end
        end
        ST_RD: begin
          if (cyc_done) begin
            rdata_out <= cyc_rdata;
            state_q <= ST_END;
          end
        end
        ST_END: begin
          done_out <= 1'b1;
          cmd_ready_out <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  fpc_cycle u_cycle (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(start_q),
    .write_in(cyc_write),
    .addr_in(cyc_addr),
    .wdata_in(step_data),
    .flash_dq_in(flash_dq_in),
    .flash_ce_b_out(flash_ce_b_out),
    .flash_oe_b_out(flash_oe_b_out),
    .flash_we_b_out(flash_we_b_out),
    .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out),
    .rdata_out(cyc_rdata),
    .done_out(cyc_done)
  );
endmodule : fpc_host

// ==== dv/fpc_host_assertions.sv ====
`timescale 1ns/1ps
module fpc_host_assertions
  import fpc_pkg::*;
#(
  parameter int PROG_LIMIT_CYC = 2000, // program poll limit
  parameter int ERASE_LIMIT_CYC = 20000 // erase poll limit
) (
  input wire logic ref_clk_in, // clock
  input wire logic rst_b_in, // reset, active low
  input wire logic cmd_valid_in, // request strobe
  input wire logic cmd_ready_out, // idle
  input wire logic done_out, // end of op
  input wire logic flash_ce_b_out, // chip enable
  input wire logic flash_oe_b_out, // output enable
  input wire logic flash_we_b_out, // write strobe
  input wire logic [fpc_pkg::AW-1:0] flash_addr_out, // address pins
  input wire logic [fpc_pkg::DW-1:0] flash_dq_out, // data pins out
  input wire logic flash_dq_oe_out // data drive enable
);
  logic [7:0] oe_hi_q;
  // counts cycles of output enable high, saturating
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) oe_hi_q <= 8'hff;
    else if (!flash_oe_b_out) oe_hi_q <= 8'h00;
    else if (oe_hi_q != 8'hff) oe_hi_q <= oe_hi_q + 8'h01;
  end
  // previous write seen on the pins, so only a true second unlock step is checked
  logic [fpc_pkg::AW+fpc_pkg::DW-1:0] wr_prev_q;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) wr_prev_q <= '0;
    else if (!flash_we_b_out) wr_prev_q <= {flash_addr_out, flash_dq_out};
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_oe_high_write: assert property (!flash_we_b_out && !flash_ce_b_out |-> flash_oe_b_out)
    else $error("output enable low during write");
  a_write_pulse_len: assert property ($fell(flash_we_b_out) |-> !flash_we_b_out [*8])
    else $error("write pulse too short");
  a_strobe_needs_ce: assert property (!flash_oe_b_out || !flash_we_b_out |-> !flash_ce_b_out)
    else $error("strobe without chip enable");
  a_oe_high_pulse: assert property ($fell(flash_oe_b_out) |-> oe_hi_q >= 8'h1e)
    else $error("output enable high pulse too short");
  a_read_addr_stable: assert property (!flash_oe_b_out && !$past(flash_oe_b_out)
    |-> $stable(flash_addr_out))
    else $error("address moved during read");
  a_write_drives_dq: assert property (!flash_we_b_out |-> flash_dq_oe_out)
    else $error("data not driven during write");
  a_unlock_byte: assert property ($fell(flash_we_b_out) && flash_addr_out == UNLOCK_ADDR2
    && wr_prev_q == {UNLOCK_ADDR1, 8'h00, CMD_UNLOCK1} |-> flash_dq_out == {8'h00, CMD_UNLOCK2})
    else $error("second unlock word wrong");
  a_done_after_busy: assert property (done_out |-> cmd_ready_out && !$past(cmd_ready_out))
    else $error("done without busy phase");
endmodule : fpc_host_assertions
bind fpc_host fpc_host_assertions #(.PROG_LIMIT_CYC(PROG_LIMIT_CYC),
  .ERASE_LIMIT_CYC(ERASE_LIMIT_CYC)) u_chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
  .flash_ce_b_out(flash_ce_b_out), .flash_oe_b_out(flash_oe_b_out),
  .flash_we_b_out(flash_we_b_out), .flash_addr_out(flash_addr_out),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out));

// ==== dv/fpc_flash_model.sv ====
`timescale 1ns/1ps
module fpc_flash_model
  import fpc_pkg::*;
#(
  parameter logic [15:0] MFR_ID = 16'h00c3, // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h0071, // arbitrary value
  parameter int PROG_T = 300, // busy cycles, program
  parameter int ERASE_T = 1500 // busy cycles, erase
) (
  input wire logic ref_clk_in, // pin sampling clock
  input wire logic stuck_in, // keep the part busy
  input wire logic ce_b_in, // chip enable
  input wire logic oe_b_in, // output enable
  input wire logic we_b_in, // write strobe
  input wire logic [14:0] addr_in, // address
  input wire logic [15:0] dq_in, // data from host
  input wire logic dq_oe_in, // host drives the data pins
  output logic [15:0] dq_out // data to host
);
  logic [15:0] mem [0:32767];
  logic [15:0] last = 16'h0000;
  logic tog = 1'b0, id = 1'b0, lock = 1'b0, we_q = 1'b1, ce_q = 1'b1, rd_q = 1'b0;
  int busy = 0, step = 0;
  wire rd = !ce_b_in && !oe_b_in;
  wire [7:0] c = dq_in[7:0];
  wire [15:0] arr = id ? (addr_in[0] ? DEV_ID : MFR_ID) : mem[addr_in];
  // released bus shows the inverse of the last word driven
  assign dq_out = !rd ? ~last : busy > 0 ? {9'h000, tog, 6'h00} : arr;
  initial for (int i = 0; i < 32768; i++) mem[i] = 16'hffff;
  always @(posedge ref_clk_in) begin
    if (rd) last <= dq_out;
    if (rd_q && !rd && busy > 0) tog <= !tog;
    if (busy > 0 && !stuck_in) busy <= busy - 1;
    rd_q <= rd;
    we_q <= we_b_in;
    ce_q <= ce_b_in;
    if (we_b_in && !we_q && !ce_q && dq_oe_in && busy == 0) begin
      case (step)
        0, 3: step = (addr_in == UNLOCK_ADDR1 && c == CMD_UNLOCK1) ? step + 1 : 0;
        1, 4: step = (addr_in == UNLOCK_ADDR2 && c == CMD_UNLOCK2) ? step + 1 : 0;
        2: begin
          step = c == CMD_PROG_SETUP ? 6 : c == CMD_ERASE_SETUP ? 3 : 0;
          if (c == CMD_ID_ENTRY) id = 1'b1;
          if (c == CMD_ID_EXIT) id = 1'b0;
        end
        5: begin
          step = 0;
          if (c == CMD_LOCKOUT) lock = 1'b1;
          // only the two erase codes clear the array; lockout leaves data alone
          if (c == CMD_CHIP_ERASE || c == CMD_MAIN_ERASE)
            for (int i = 0; i < 32768; i++)
              if (i > 32'h1fff || (c == CMD_CHIP_ERASE && !lock)) mem[i] = 16'hffff;
          busy = ERASE_T;
        end
        6: begin
          step = 0;
          if (!(lock && addr_in <= BOOT_HI_ADDR)) mem[addr_in] = dq_in;
          busy = PROG_T;
        end
        default: step = 0;
      endcase
    end
  end
endmodule : fpc_flash_model

// ==== dv/fpc_host_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module fpc_host_tb_top;
  import fpc_pkg::*;
  typedef struct {logic chk; logic [15:0] d; logic to;} fpc_note_t;
  logic ref_clk_in = 0, rst_b_in = 0, cmd_valid_in = 0, stuck = 0;
  fpc_op_t cmd_op_in = FPC_OP_READ;
  logic [AW-1:0] cmd_addr_in = '0, fa;
  logic [DW-1:0] cmd_wdata_in = '0, rdata_out, dq_in, dq_out;
  logic cmd_ready_out, done_out, timeout_out, boot_hit_out, ce_b, oe_b, we_b, dq_oe;
  fpc_note_t notes[$];
  fpc_note_t nt;
  int bad_count = 0, n_compared = 0, seed = 32'h6e2c;
  logic [14:0] a;
  logic [15:0] d;
  always #2.5 ref_clk_in = ~ref_clk_in;
  fpc_host #(.PROG_LIMIT_CYC(2000), .ERASE_LIMIT_CYC(20000)) uut (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out), .rdata_out(rdata_out), .timeout_out(timeout_out),
    .boot_hit_out(boot_hit_out), .flash_dq_in(dq_in), .flash_ce_b_out(ce_b),
    .flash_oe_b_out(oe_b), .flash_we_b_out(we_b), .flash_addr_out(fa),
    .flash_dq_out(dq_out), .flash_dq_oe_out(dq_oe));
  fpc_flash_model u_flash (.ref_clk_in(ref_clk_in), .stuck_in(stuck), .ce_b_in(ce_b),
    .oe_b_in(oe_b), .we_b_in(we_b), .addr_in(fa), .dq_in(dq_out), .dq_oe_in(dq_oe),
    .dq_out(dq_in));
  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  always @(negedge ref_clk_in) begin
    if (rst_b_in && done_out === 1'b1) begin
      nt = notes.pop_front();
      if (nt.chk) `CHK("rdata_out", nt.d, rdata_out)
      `CHK("timeout_out", nt.to, timeout_out)
    end
  end
  task automatic op(input fpc_op_t o, input logic [14:0] ad, input logic [15:0] wd,
      input logic chk, input logic [15:0] ex, input logic to);
    int n;
    n = 0;
    notes.push_back('{chk, ex, to});
    @(posedge ref_clk_in);
    cmd_op_in <= o;
    cmd_addr_in <= ad;
    cmd_wdata_in <= wd;
    cmd_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b0;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      bad_count++;
      $display("ERROR done_out expected 1 seen 0");
      final_report();
    end
  endtask : op
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    op(FPC_OP_ID_READ, 15'h0000, 16'h0000, 1, 16'h00c3, 0);
    op(FPC_OP_ID_READ, 15'h0001, 16'h0000, 1, 16'h0071, 0);
    op(FPC_OP_ID_EXIT, 15'h0000, 16'h0000, 0, 16'h0000, 0);
    op(FPC_OP_READ, 15'h0001, 16'h0000, 1, 16'hffff, 0);
    repeat (3) begin
      a = 15'h2000 | (15'($random(seed)) & 15'h0ff0);
      d = 16'($random(seed));
      op(FPC_OP_PROG, a, d, 0, 16'h0000, 0);
      `CHK("boot_hit_out", 1'b0, boot_hit_out)
      op(FPC_OP_READ, a, 16'h0000, 1, d, 0);
    end
    op(FPC_OP_PROG, 15'h0010, 16'h1234, 0, 16'h0000, 0);
    `CHK("boot_hit_out", 1'b1, boot_hit_out)
    op(FPC_OP_MAIN_ERASE, a, 16'h0000, 0, 16'h0000, 0);
    op(FPC_OP_READ, a, 16'h0000, 1, 16'hffff, 0);
    op(FPC_OP_READ, 15'h0010, 16'h0000, 1, 16'h1234, 0);
    op(FPC_OP_CHIP_ERASE, a, 16'h0000, 0, 16'h0000, 0);
    op(FPC_OP_READ, 15'h0010, 16'h0000, 1, 16'hffff, 0);
    op(FPC_OP_PROG, 15'h0010, 16'h5aa5, 0, 16'h0000, 0);
    op(FPC_OP_LOCKOUT, a, 16'h0000, 0, 16'h0000, 0);
    op(FPC_OP_PROG, 15'h1fff, 16'h0000, 0, 16'h0000, 0);
    op(FPC_OP_READ, 15'h1fff, 16'h0000, 1, 16'hffff, 0);
    op(FPC_OP_PROG, 15'h2000, 16'h0bcd, 0, 16'h0000, 0);
    op(FPC_OP_READ, 15'h2000, 16'h0000, 1, 16'h0bcd, 0);
    op(FPC_OP_CHIP_ERASE, a, 16'h0000, 0, 16'h0000, 0);
    op(FPC_OP_READ, 15'h0010, 16'h0000, 1, 16'h5aa5, 0);
    op(FPC_OP_READ, 15'h2000, 16'h0000, 1, 16'hffff, 0);
    stuck <= 1'b1;
    op(FPC_OP_PROG, 15'h3000, 16'h0001, 0, 16'h0000, 1);
    stuck <= 1'b0;
    repeat (400) @(posedge ref_clk_in);
    op(FPC_OP_READ, 15'h3000, 16'h0000, 1, 16'h0001, 0);
    final_report();
  end
endmodule : fpc_host_tb_top
